/* rtl/pixel_scan_params.svh */
`ifndef PIXEL_SCAN_PARAMS_SVH
`define PIXEL_SCAN_PARAMS_SVH

// output slots per scan and clocks per scan
`define SCAN_SLOTS 8'h84
`define SCAN_CLOCKS 8'h85
// integrator reset spans this many scan clocks from the start capture
`define INTEG_RESET_CLKS 8'h12
// first and last real pixel slot
`define FIRST_REAL_SLOT 8'h03
`define LAST_REAL_SLOT 8'h82
// settle time after the last scan clock, and reference clock period
`define SETTLE_TIME_NS 32'h2710
`define REF_CLK_PERIOD_NS 32'h14
`define SETTLE_CYCLES ((`SETTLE_TIME_NS + `REF_CLK_PERIOD_NS - 32'h1) / `REF_CLK_PERIOD_NS)
// reference cycles per scan clock half period (25 gives 1 MHz)
`define SCAN_HALF_DIV 32'h19
// width of the digital stand-in for the analog pixel level
`define PIX_WIDTH 32'h8

`endif

/* rtl/pixel_scan_pkg.sv */
package pixel_scan_pkg;

	typedef logic [7:0] slot_type;

	// gray coded along idle, setup, run, settle
	typedef enum logic [1:0] {
		HOST_IDLE = 2'h0,
		HOST_SETUP = 2'h1,
		HOST_RUN = 2'h3,
		HOST_SETTLE = 2'h2
	} host_state_type;

endpackage

/* rtl/pixel_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pixel_scan_params.svh"

interface pixel_link_if #(
	parameter int PIX_W = `PIX_WIDTH
);
	logic scan_clk;
	logic scan_start;
	logic [PIX_W-1:0] analog_pixel_output;
	logic pixel_oe;
	// pin level seen on the board: high impedance reads as all zero through the pulldown
	logic [PIX_W-1:0] pixel_pin;

	assign pixel_pin = pixel_oe ? analog_pixel_output : '0;

	modport sensor (
		input scan_clk,
		input scan_start,
		output analog_pixel_output,
		output pixel_oe
	);

	modport host (
		output scan_clk,
		output scan_start,
		input pixel_pin
	);
endinterface

`default_nettype wire

/* rtl/scan_sensor_end.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pixel_scan_params.svh"

module scan_sensor_end
	import pixel_scan_pkg::*;
#(
	parameter int PIX_W = `PIX_WIDTH
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	pixel_link_if.sensor link,
	input wire logic [PIX_W-1:0] i_held_value,
	output logic [7:0] o_slot_index,
	output logic o_sample_freeze,
	output logic o_integ_reset,
	output logic o_chain_primed
);

	logic [2:0] clk_sync_q;
	logic [2:0] clk_sync_d;
	logic [1:0] start_sync_q;
	logic [1:0] start_sync_d;
	slot_type pos_q;
	slot_type pos_d;
	slot_type rst_cnt_q;
	slot_type rst_cnt_d;
	logic integ_reset_q;
	logic integ_reset_d;
	logic primed_q;
	logic primed_d;
	logic freeze_q;
	logic freeze_d;
	logic [PIX_W-1:0] out_q;
	logic [PIX_W-1:0] out_d;
	logic oe_q;
	logic oe_d;
	logic clk_rise;
	logic start_seen;

	function automatic logic is_real(input slot_type s);
		return (s >= `FIRST_REAL_SLOT) && (s <= `LAST_REAL_SLOT);
	endfunction

	always_comb begin
		// both pins share the same two-stage delay, so edge and start stay aligned
		clk_sync_d = {clk_sync_q[1:0], link.scan_clk};
		start_sync_d = {start_sync_q[0], link.scan_start};
		clk_rise = clk_sync_q[1] & ~clk_sync_q[2];
		start_seen = clk_rise & start_sync_q[1];
		pos_d = pos_q;
		rst_cnt_d = rst_cnt_q;
		integ_reset_d = integ_reset_q;
		primed_d = primed_q;
		freeze_d = start_seen;
		if (start_seen) begin
			pos_d = 8'h01;
			rst_cnt_d = 8'h01;
			integ_reset_d = 1'b1;
		end else if (clk_rise) begin
			if (pos_q == `SCAN_SLOTS) begin
				// last clock only re-initialises the chain
				pos_d = 8'h00;
				primed_d = 1'b1;
			end else if (pos_q != 8'h00) begin
				pos_d = pos_q + 8'h01;
			end
			if (integ_reset_q) begin
				rst_cnt_d = rst_cnt_q + 8'h01;
				if (rst_cnt_q == `INTEG_RESET_CLKS - 8'h01) begin
					integ_reset_d = 1'b0;
				end
			end
		end
		// dummy slots carry a zero level
		out_d = is_real(pos_d) ? i_held_value : '0;
		oe_d = (pos_d != 8'h00);
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			clk_sync_q <= 3'h0;
			start_sync_q <= 2'h0;
			pos_q <= 8'h00;
			rst_cnt_q <= 8'h00;
			integ_reset_q <= 1'b0;
			primed_q <= 1'b0;
			freeze_q <= 1'b0;
			out_q <= '0;
			oe_q <= 1'b0;
		end else begin
			clk_sync_q <= clk_sync_d;
			start_sync_q <= start_sync_d;
			pos_q <= pos_d;
			rst_cnt_q <= rst_cnt_d;
			integ_reset_q <= integ_reset_d;
			primed_q <= primed_d;
			freeze_q <= freeze_d;
			out_q <= out_d;
			oe_q <= oe_d;
		end
	end

	// user returns the held level for this slot in the same cycle
	assign o_slot_index = pos_d;
	assign o_sample_freeze = freeze_q;
	assign o_integ_reset = integ_reset_q;
	assign o_chain_primed = primed_q;
	assign link.analog_pixel_output = out_q;
	assign link.pixel_oe = oe_q;

endmodule

`default_nettype wire

/* rtl/scan_host_end.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pixel_scan_params.svh"

module scan_host_end
	import pixel_scan_pkg::*;
#(
	parameter int PIX_W = `PIX_WIDTH,
	parameter int HALF_DIV = `SCAN_HALF_DIV,
	parameter int SETTLE_CYC = `SETTLE_CYCLES
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	pixel_link_if.host link,
	input wire logic i_scan_req,
	output logic o_busy,
	output logic [PIX_W-1:0] o_pixel_data,
	output logic o_pixel_valid,
	output logic o_pixel_real,
	output logic [7:0] o_slot_num,
	output logic o_scan_valid,
	output logic o_scan_done
);

	localparam logic [15:0] HALF_LAST = 16'(HALF_DIV - 1);
	localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYC - 1);

	host_state_type state_q;
	host_state_type state_d;
	logic [15:0] div_q;
	logic [15:0] div_d;
	logic clk_q;
	logic clk_d;
	logic start_q;
	logic start_d;
	slot_type pulses_q;
	slot_type pulses_d;
	logic primed_q;
	logic primed_d;
	logic scan_ok_q;
	logic scan_ok_d;
	logic [PIX_W-1:0] data_q;
	logic [PIX_W-1:0] data_d;
	logic valid_q;
	logic valid_d;
	logic real_q;
	logic real_d;
	slot_type slot_q;
	slot_type slot_d;
	logic done_q;
	logic done_d;
	logic div_hit;

	function automatic logic is_real(input slot_type s);
		return (s >= `FIRST_REAL_SLOT) && (s <= `LAST_REAL_SLOT);
	endfunction

	always_comb begin
		state_d = state_q;
		div_d = div_q + 16'h0001;
		clk_d = clk_q;
		start_d = start_q;
		pulses_d = pulses_q;
		primed_d = primed_q;
		scan_ok_d = scan_ok_q;
		data_d = data_q;
		valid_d = 1'b0;
		real_d = real_q;
		slot_d = slot_q;
		done_d = 1'b0;
		div_hit = 1'b0;
		case (state_q)
			HOST_IDLE: begin
				div_d = 16'h0000;
				clk_d = 1'b0;
				// only idle takes a request, so no start lands mid-readout
				if (i_scan_req) begin
					state_d = HOST_SETUP;
					start_d = 1'b1;
					// data of the first scan after power-on is not trusted
					scan_ok_d = primed_q;
				end
			end
			HOST_SETUP: begin
				// start stands one half period before the capturing edge
				div_hit = (div_q == HALF_LAST);
				if (div_hit) begin
					div_d = 16'h0000;
					clk_d = 1'b1;
					pulses_d = 8'h01;
					state_d = HOST_RUN;
				end
			end
			HOST_RUN: begin
				div_hit = (div_q == HALF_LAST);
				if (div_hit) begin
					div_d = 16'h0000;
					if (clk_q) begin
						clk_d = 1'b0;
						// start falls half a period before the next rise
						start_d = 1'b0;
						if (pulses_q == `SCAN_CLOCKS) begin
							state_d = HOST_SETTLE;
						end
					end else begin
						clk_d = 1'b1;
						pulses_d = pulses_q + 8'h01;
						// sample the slot presented since the previous rise
						if (pulses_q != 8'h00) begin
							data_d = link.pixel_pin;
							valid_d = 1'b1;
							slot_d = pulses_q;
							real_d = is_real(pulses_q);
						end
					end
				end
			end
			HOST_SETTLE: begin
				// hold-off also keeps integration above its minimum
				if (div_q == SETTLE_LAST) begin
					div_d = 16'h0000;
					state_d = HOST_IDLE;
					primed_d = 1'b1;
					done_d = 1'b1;
				end
			end
			default: begin
				state_d = HOST_IDLE;
				div_d = 16'h0000;
				clk_d = 1'b0;
				start_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			state_q <= HOST_IDLE;
			div_q <= 16'h0000;
			clk_q <= 1'b0;
			start_q <= 1'b0;
			pulses_q <= 8'h00;
			primed_q <= 1'b0;
			scan_ok_q <= 1'b0;
			data_q <= '0;
			valid_q <= 1'b0;
			real_q <= 1'b0;
			slot_q <= 8'h00;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			div_q <= div_d;
			clk_q <= clk_d;
			start_q <= start_d;
			pulses_q <= pulses_d;
			primed_q <= primed_d;
			scan_ok_q <= scan_ok_d;
			data_q <= data_d;
			valid_q <= valid_d;
			real_q <= real_d;
			slot_q <= slot_d;
			done_q <= done_d;
		end
	end

	// scan clock stands low outside a scan
	assign link.scan_clk = clk_q;
	assign link.scan_start = start_q;
	assign o_busy = (state_q != HOST_IDLE);
	assign o_pixel_data = data_q;
	assign o_pixel_valid = valid_q;
	assign o_pixel_real = real_q;
	assign o_slot_num = slot_q;
	assign o_scan_valid = scan_ok_q;
	assign o_scan_done = done_q;

endmodule

`default_nettype wire

/* dv/pixel_link_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module pixel_link_sva #(
	parameter int PIX_W = 8,
	parameter int SETTLE_CYC = 4
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic scan_clk,
	input wire logic scan_start,
	input wire logic [PIX_W-1:0] analog_pixel_output,
	input wire logic pixel_oe,
	input wire logic [PIX_W-1:0] pixel_pin
);
	logic clk_q, rise;
	logic [7:0] cnt_q, cnt_d;
	logic [15:0] gap_q, gap_d;
	// rise number within the scan; parks at 133 until the next start
	assign rise = scan_clk & ~clk_q;
	always_comb begin
		cnt_d = cnt_q;
		if (rise && scan_start) cnt_d = 8'h01;
		else if (rise && cnt_q != 8'h00 && cnt_q < 8'h85) cnt_d = cnt_q + 8'h01;
		gap_d = scan_clk ? 16'h0000 : gap_q + {15'h0000, ~&gap_q};
	end
	always_ff @(posedge i_ref_clk) begin
		clk_q <= i_rst_n & scan_clk;
		cnt_q <= i_rst_n ? cnt_d : 8'h00;
		gap_q <= i_rst_n ? gap_d : 16'h0000;
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_cap; rise && scan_start; endsequence
	sequence s_last; rise && cnt_q == 8'h84; endsequence
	property p_oe_on; s_cap |-> ##[3:5] pixel_oe; endproperty
	property p_oe_off; s_last |-> ##[3:5] !pixel_oe; endproperty
	property p_oe_hold; cnt_q >= 8'h02 && cnt_q <= 8'h84 |-> pixel_oe; endproperty
	property p_fell; $fell(pixel_oe) |-> cnt_q == 8'h85; endproperty
	property p_midstart; rise && cnt_q != 8'h00 && cnt_q != 8'h85 |-> !scan_start; endproperty
	property p_count; rise && cnt_q == 8'h85 |-> scan_start; endproperty
	// measured up to the start edge itself, so the setup half period cannot hide a short hold-off
	property p_settle; $rose(scan_start) && cnt_q == 8'h85 |-> gap_q >= SETTLE_CYC; endproperty
	// output lags the slot count by two reference cycles
	property p_dummy; pixel_oe && ($past(cnt_q, 2) <= 8'h02 || $past(cnt_q, 2) >= 8'h83) |-> analog_pixel_output == '0;
	endproperty
	property p_released; $past(cnt_q, 2) == 8'h85 |-> pixel_pin == '0; endproperty
	property p_clk_high; $rose(scan_clk) |-> scan_clk [*6]; endproperty
	a_oe_on: assert property (p_oe_on) else $error("output not driven after start");
	a_oe_off: assert property (p_oe_off) else $error("output still driven after last clock");
	a_oe_hold: assert property (p_oe_hold) else $error("output dropped inside the scan");
	a_fell: assert property (p_fell) else $error("output released early");
	a_midstart: assert property (p_midstart) else $error("start seen inside a scan");
	a_count: assert property (p_count) else $error("extra scan clock");
	a_settle: assert property (p_settle) else $error("start too soon after last clock");
	a_clk_high: assert property (p_clk_high) else $error("scan clock pulse too short");
	a_dummy: assert property (p_dummy) else $error("dummy slot carries a level");
	a_released: assert property (p_released) else $error("pin not released after last slot");
endmodule
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pixel_scan_params.svh"
module testbench;
	logic i_ref_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_scan_req = 1'b0;
	logic [7:0] held, slot_idx, pix, slot;
	logic busy, pvalid, preal, svalid, done, freeze, integ, primed;
	int num_errors = 0;
	int cmp_count = 0;
	pixel_link_if link ();
	always #10 i_ref_clk = ~i_ref_clk;
	// distinct level per slot so a shifted slot shows up as a data error
	assign held = slot_idx ^ 8'hA5;
	scan_sensor_end i_scan_sensor_end (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .link(link),
		.i_held_value(held), .o_slot_index(slot_idx), .o_sample_freeze(freeze),
		.o_integ_reset(integ), .o_chain_primed(primed));
	scan_host_end #(.HALF_DIV(6), .SETTLE_CYC(4)) i_scan_host_end (.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n), .link(link), .i_scan_req(i_scan_req), .o_busy(busy),
		.o_pixel_data(pix), .o_pixel_valid(pvalid), .o_pixel_real(preal), .o_slot_num(slot),
		.o_scan_valid(svalid), .o_scan_done(done));
	pixel_link_sva #(.PIX_W(8), .SETTLE_CYC(4)) i_pixel_link_sva (.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n), .scan_clk(link.scan_clk), .scan_start(link.scan_start),
		.analog_pixel_output(link.analog_pixel_output), .pixel_oe(link.pixel_oe),
		.pixel_pin(link.pixel_pin));
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic close_out;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// request stays up well into the scan; the extra cycles must be ignored
	task automatic run_scan(input logic exp_valid);
		int n, ns, nint, nfrz;
		logic prev, rl;
		n = 0;
		ns = 0;
		nint = 0;
		nfrz = 0;
		prev = 1'b0;
		do begin
			@(posedge i_ref_clk);
			i_scan_req <= (n < 40);
			#1;
			n++;
			if (pvalid === 1'b1) begin
				ns++;
				rl = (ns >= 3 && ns <= 130);
				if (ns == 1) chk("busy", 1, busy);
				chk("slot", ns, slot);
				chk("real", rl, preal);
				chk("data", rl ? (ns ^ 8'hA5) : 0, pix);
			end
			if (link.scan_clk === 1'b1 && prev === 1'b0 && integ === 1'b1) nint++;
			if (freeze === 1'b1) nfrz++;
			prev = link.scan_clk;
		end while (done !== 1'b1 && n < 5000);
		chk("done", 1, done);
		chk("busy", 0, busy);
		chk("slots", `SCAN_SLOTS, ns);
		chk("integ", `INTEG_RESET_CLKS - 8'h01, nint);
		chk("freeze", 1, nfrz);
		chk("scan_valid", exp_valid, svalid);
		chk("primed", 1, primed);
		chk("oe", 0, link.pixel_oe);
		chk("pin", 0, link.pixel_pin);
	endtask
	initial begin
		repeat (6) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		@(posedge i_ref_clk);
		#1;
		chk("primed", 0, primed);
		run_scan(1'b0);
		run_scan(1'b1);
		run_scan(1'b1);
		close_out();
	end
	// three scans need about 4800 cycles
	initial begin
		#400000;
		num_errors++;
		close_out();
	end
endmodule
`default_nettype wire
